// [lcdh_defs.svh]
`ifndef LCDH_DEFS_SVH
`define LCDH_DEFS_SVH
// Device register addresses on the memory-mapped side bus.
`define LCDH_DEV_SUBSYSTEM_CLOCK_OPTION_ADDR 20'hF00F3
`define LCDH_DEV_ISC_ADDR 20'hF0308
`define LCDH_DEV_MODE0_ADDR 20'hFFF40
`define LCDH_DEV_MODE1_ADDR 20'hFFF41
`define LCDH_DEV_CLK_ADDR 20'hFFF42
`define LCDH_DEV_LVL_ADDR 20'hFFF43
// Reset values.
`define LCDH_LVL_RESET 8'h04
// Field positions in the mode control 1 and subsystem clock option registers.
`define LCDH_M1_DISP 7
`define LCDH_M1_SEG 6
`define LCDH_M1_BOOST 5
`define LCDH_M1_BLINK 4
`define LCDH_M1_AREA 3
`define LCDH_M1_PINIT 0
`define LCDH_SUBSYSTEM_CLOCK_OPTION_LPC 7
`define LCDH_SUBSYSTEM_CLOCK_OPTION_SEL 4
// Own register byte offsets on AHB-Lite.
`define LCDH_R_CMD 8'h00
`define LCDH_R_WDATA 8'h04
`define LCDH_R_STATUS 8'h08
`define LCDH_R_RDATA 8'h0C
`define LCDH_R_WAIT 8'h10
// Reference settle time.
`define LCDH_SETTLE_MS 5
`define LCDH_CLK_MHZ 100
`define LCDH_SETTLE_CYC (`LCDH_SETTLE_MS * 1000 * `LCDH_CLK_MHZ)
`endif

// [lcdh_pkg.sv]
package lcdh_pkg;
  typedef enum logic [2:0] {
    LCDH_IDLE = 3'b000,
    LCDH_WR = 3'b001,
    LCDH_RD = 3'b010,
    LCDH_RDW = 3'b011,
    LCDH_SETTLE = 3'b100
  } lcdh_state_t;
  typedef enum logic [2:0] {
    LCDH_K_SUBSYSTEM_CLOCK_OPTION = 3'b000,
    LCDH_K_ISC = 3'b001,
    LCDH_K_MODE0 = 3'b010,
    LCDH_K_MODE1 = 3'b011,
    LCDH_K_CLK = 3'b100,
    LCDH_K_LVL = 3'b101
  } lcdh_reg_t;
endpackage : lcdh_pkg

// [lcdh_ctrl.sv]
`timescale 1ns/1ps
`include "lcdh_defs.svh"
// Function
// - Never set boost enable while external resistance division is selected.
// - Keep blink zero when low-speed oscillator clocks the display.
// - Pin init bit one for internal boosting, zero for other methods.
// - Clear pin init bit for resistance division or capacitor split.
// - No rewrite of boost enable or pin init while segments output.
// - Blink and area select stay zero with eight time slices.
// - Program reference, wait at least 5 ms, then set boost enable.
// - Idle display: clear segment output, boost enable, generator select zero.
// - Clock select changes once only, while display and boost stopped.
// - No clock register write while segments output; bits 7:6 zero.
// - Boost or split needs slow enough display clock.
// - Change reference only with boost disabled; bits 7:5 written zero.
// - Leave reference at 04h for resistance division or capacitor split.
// - Keep Schmitt inputs of shared pins off until pins switch.
module lcdh_ctrl
  import lcdh_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device register port.
  output logic [19:0] dev_addr,
  output logic [7:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [7:0] dev_rdata
);
  logic [7:0] dev_rdata_s1_q;
  logic [7:0] dev_rdata_s2_q;
  lcdh_state_t state_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q;
  logic [2:0] cmd_reg_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] mode0_q;
  logic [7:0] mode1_q;
  logic [7:0] clk_q;
  logic [7:0] lvl_q;
  logic [7:0] isc_q;
  logic [7:0] subsystem_clock_option_q;
  logic subsystem_clock_option_done_q;
  logic [1:0] err_q;
  logic [31:0] settle_cnt_q;
  logic [1:0] rd_cnt_q;
  logic start;
  logic [7:0] wv;
  logic bad;
  logic [19:0] tgt;
  logic [1:0] gen;
  logic seg_on;
  logic eight_slices;

  assign gen = mode0_q[7:6];
  assign seg_on = mode1_q[`LCDH_M1_SEG];
  assign eight_slices = (mode0_q[4:2] == 3'h5);

  // Input from the device side crosses in through two flops.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dev_rdata_s1_q <= 8'h00;
      dev_rdata_s2_q <= 8'h00;
    end else begin
      dev_rdata_s1_q <= dev_rdata;
      dev_rdata_s2_q <= dev_rdata_s1_q;
    end
  end

  // Address phase capture.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_wr_q <= hsel && htrans[1] && hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end

  assign start = ap_wr_q && (ap_addr_q == `LCDH_R_CMD) && (state_q == LCDH_IDLE);
  assign wv = hwdata[7:0];

  always_comb begin
    tgt = `LCDH_DEV_SUBSYSTEM_CLOCK_OPTION_ADDR;
    case (hwdata[10:8])
      LCDH_K_SUBSYSTEM_CLOCK_OPTION: tgt = `LCDH_DEV_SUBSYSTEM_CLOCK_OPTION_ADDR;
      LCDH_K_ISC: tgt = `LCDH_DEV_ISC_ADDR;
      LCDH_K_MODE0: tgt = `LCDH_DEV_MODE0_ADDR;
      LCDH_K_MODE1: tgt = `LCDH_DEV_MODE1_ADDR;
      LCDH_K_CLK: tgt = `LCDH_DEV_CLK_ADDR;
      LCDH_K_LVL: tgt = `LCDH_DEV_LVL_ADDR;
      default: tgt = `LCDH_DEV_SUBSYSTEM_CLOCK_OPTION_ADDR;
    endcase
  end

  // Guards that refuse writes the device forbids.
  always_comb begin
    bad = 1'b0;
    if (hwdata[11]) begin
      bad = 1'b0;
    end else begin
      case (hwdata[10:8])
        LCDH_K_MODE1: begin
          if (wv[`LCDH_M1_BOOST] && gen == 2'b00) bad = 1'b1;
          if (wv[`LCDH_M1_BLINK] && subsystem_clock_option_q[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL]) bad = 1'b1;
          if (wv[`LCDH_M1_PINIT] != (gen == 2'b01)) bad = 1'b1;
          if (seg_on && (wv[`LCDH_M1_BOOST] != mode1_q[`LCDH_M1_BOOST]
              || wv[`LCDH_M1_PINIT] != mode1_q[`LCDH_M1_PINIT])) bad = 1'b1;
          if (eight_slices && (wv[`LCDH_M1_BLINK] || wv[`LCDH_M1_AREA])) bad = 1'b1;
          if (wv[`LCDH_M1_BOOST] && !mode1_q[`LCDH_M1_BOOST]
              && settle_cnt_q != 32'h0) bad = 1'b1;
        end
        LCDH_K_MODE0: if (seg_on) bad = 1'b1;
        LCDH_K_SUBSYSTEM_CLOCK_OPTION: begin
          if (subsystem_clock_option_done_q && wv[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL] != subsystem_clock_option_q[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL]) bad = 1'b1;
          if (wv[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL] != subsystem_clock_option_q[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL]
              && (seg_on || mode1_q[`LCDH_M1_BOOST])) bad = 1'b1;
          if (wv[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL] && mode1_q[`LCDH_M1_BLINK]) bad = 1'b1;
        end
        LCDH_K_CLK: begin
          if (seg_on || wv[7:6] != 2'b00) bad = 1'b1;
          if (!((wv >= 8'h04 && wv <= 8'h09) || (wv >= 8'h11 && wv <= 8'h1B)
              || wv == 8'h2B)) bad = 1'b1;
          if (wv == 8'h09 && subsystem_clock_option_q[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL]) bad = 1'b1;
          if (gen != 2'b00 && wv >= 8'h04 && wv <= 8'h09
              && wv < (subsystem_clock_option_q[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL] ? 8'h07 : 8'h06)) bad = 1'b1;
        end
        LCDH_K_LVL: begin
          if (mode1_q[`LCDH_M1_BOOST] || wv[7:5] != 3'h0) bad = 1'b1;
          if (wv < 8'h04 || wv > 8'h13) bad = 1'b1;
          if (mode0_q[1:0] == 2'b10 && wv > 8'h0A) bad = 1'b1;
          if (gen != 2'b01 && wv != `LCDH_LVL_RESET) bad = 1'b1;
        end
        LCDH_K_ISC: if (wv[7:2] != 6'h00) bad = 1'b1;
        default: bad = 1'b1;
      endcase
    end
  end

  // Command engine.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LCDH_IDLE;
      dev_addr <= 20'h00000;
      dev_wdata <= 8'h00;
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
      cmd_reg_q <= 3'h0;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      rd_cnt_q <= 2'h0;
      err_q <= 2'h0;
    end else begin
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
      case (state_q)
        LCDH_IDLE: begin
          if (start) begin
            cmd_reg_q <= hwdata[10:8];
            wdata_q <= wv;
            dev_addr <= tgt;
            if (hwdata[11]) begin
              dev_rd <= 1'b1;
              rd_cnt_q <= 2'h3;
              state_q <= LCDH_RD;
              err_q <= 2'h0;
            end else if (bad) begin
              err_q <= 2'h1;
            end else begin
              dev_wdata <= wv;
              dev_wr <= 1'b1;
              err_q <= 2'h0;
              state_q <= LCDH_WR;
            end
          end
        end
        LCDH_WR: state_q <= LCDH_IDLE;
        LCDH_RD: begin
          if (rd_cnt_q == 2'h0) begin
            rdata_q <= dev_rdata_s2_q;
            state_q <= LCDH_IDLE;
          end else begin
            rd_cnt_q <= rd_cnt_q - 2'h1;
          end
        end
        default: state_q <= LCDH_IDLE;
      endcase
    end
  end

  // Shadow copies of what was written into the device.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode0_q <= 8'h00;
      mode1_q <= 8'h00;
      clk_q <= 8'h00;
      lvl_q <= `LCDH_LVL_RESET;
      isc_q <= 8'h00;
      subsystem_clock_option_q <= 8'h00;
      subsystem_clock_option_done_q <= 1'b0;
    end else if (state_q == LCDH_WR) begin
      case (cmd_reg_q)
        LCDH_K_MODE0: mode0_q <= wdata_q;
        LCDH_K_MODE1: mode1_q <= wdata_q;
        LCDH_K_CLK: clk_q <= wdata_q;
        LCDH_K_LVL: lvl_q <= wdata_q;
        LCDH_K_ISC: isc_q <= wdata_q;
        LCDH_K_SUBSYSTEM_CLOCK_OPTION: begin
          subsystem_clock_option_q <= wdata_q;
          if (wdata_q[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL] != subsystem_clock_option_q[`LCDH_SUBSYSTEM_CLOCK_OPTION_SEL]) subsystem_clock_option_done_q <= 1'b1;
        end
        default: mode0_q <= mode0_q;
      endcase
    end
  end

  // Reference settle timer restarts on level or generator programming.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_q <= 32'h0;
    end else if (state_q == LCDH_WR
        && (cmd_reg_q == LCDH_K_LVL || cmd_reg_q == LCDH_K_MODE0)) begin
      settle_cnt_q <= 32'(`LCDH_SETTLE_CYC);
    end else if (settle_cnt_q != 32'h0) begin
      settle_cnt_q <= settle_cnt_q - 32'h1;
    end
  end

  // Register reads; zero wait states.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `LCDH_R_STATUS: hrdata <= {8'h00, subsystem_clock_option_q, mode1_q, 3'h0,
          subsystem_clock_option_done_q, err_q, state_q != LCDH_IDLE, settle_cnt_q != 32'h0};
        `LCDH_R_RDATA: hrdata <= {24'h0, rdata_q};
        `LCDH_R_WAIT: hrdata <= settle_cnt_q;
        `LCDH_R_WDATA: hrdata <= {8'h00, lvl_q, clk_q, mode0_q};
        default: hrdata <= {24'h0, isc_q};
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  sequence boost_set_s;
    dev_wr && dev_addr == `LCDH_DEV_MODE1_ADDR && dev_wdata[`LCDH_M1_BOOST];
  endsequence

  boost_gen_a: assert property (@(posedge mclk) disable iff (!rst_n)
    boost_set_s |-> gen != 2'b00) else $error("boost set in resistance mode");
  settle_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (boost_set_s and !mode1_q[`LCDH_M1_BOOST]) |-> settle_cnt_q == 32'h0)
    else $error("boost set before settle");
  clk_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_wr && dev_addr == `LCDH_DEV_CLK_ADDR |-> !seg_on && dev_wdata[7:6] == 2'b00)
    else $error("bad clock write");
  lvl_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_wr && dev_addr == `LCDH_DEV_LVL_ADDR |-> !mode1_q[`LCDH_M1_BOOST])
    else $error("level changed while boosting");
  write_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_wr |=> !dev_wr ##1 state_q == LCDH_IDLE) else $error("write pulse long");
  read_time_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_rd |-> ##4 state_q == LCDH_IDLE) else $error("read not done");
  blink_eight_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_wr && dev_addr == `LCDH_DEV_MODE1_ADDR && eight_slices
    |-> !dev_wdata[`LCDH_M1_BLINK] && !dev_wdata[`LCDH_M1_AREA])
    else $error("blink with eight slices");
  pinit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_wr && dev_addr == `LCDH_DEV_MODE1_ADDR
    |-> dev_wdata[`LCDH_M1_PINIT] == (gen == 2'b01)) else $error("pin init mismatch");
endmodule : lcdh_ctrl

// [lcdh_dev_model.sv]
`timescale 1ns/1ps
`include "lcdh_defs.svh"
module lcdh_dev_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Device register port.
  input wire logic [19:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [7:0] dev_rdata
);
  logic [7:0] reg_q [6];
  logic [7:0] last_q;
  logic [2:0] hold_q;
  int idx;
  always_comb begin
    case (dev_addr)
      `LCDH_DEV_SUBSYSTEM_CLOCK_OPTION_ADDR: idx = 0;
      `LCDH_DEV_ISC_ADDR: idx = 1;
      `LCDH_DEV_MODE0_ADDR: idx = 2;
      `LCDH_DEV_MODE1_ADDR: idx = 3;
      `LCDH_DEV_CLK_ADDR: idx = 4;
      `LCDH_DEV_LVL_ADDR: idx = 5;
      default: idx = 6;
    endcase
  end
  // Stored bits set boost, patterns, clock source, divider, reference and input gates.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) begin
        reg_q[i] <= (i == 5) ? `LCDH_LVL_RESET : 8'h00;
      end
    end else if (dev_wr && idx < 6) begin
      reg_q[idx] <= dev_wdata;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 8'h00;
      hold_q <= 3'h0;
    end else if (dev_rd) begin
      last_q <= (idx < 6) ? reg_q[idx] : 8'h00;
      hold_q <= 3'h6;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
  // After the hold runs out the bus shows the inverse, never stale data.
  assign dev_rdata = (hold_q != 3'h0) ? last_q : ~last_q;
endmodule : lcdh_dev_model

// [lcdh_ctrl_tb_top.sv]
`timescale 1ns/1ps
`include "lcdh_defs.svh"
module lcdh_ctrl_tb_top;
  import lcdh_pkg::*;
  logic mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp, dev_wr, dev_rd;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [19:0] dev_addr;
  logic [7:0] dev_wdata, dev_rdata;
  int err_count, check_count;
  assign hready = hreadyout;
  lcdh_ctrl uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
  lcdh_dev_model u_dev (.mclk(mclk), .rst_n(rst_n), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge mclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) begin
        check("hready wait", 32'h1, 32'h0);
        end_sim();
      end
      @(posedge mclk);
    end
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd_v = hrdata;
    check("response", 32'h0, {31'h0, hresp});
  endtask : ahb
  task automatic cmd(input lcdh_reg_t r, input logic [7:0] v, input logic rd);
    int n;
    n = 0;
    ahb(1'b1, {24'h0, `LCDH_R_CMD}, {20'h0, rd, r, v});
    do begin
      ahb(1'b0, {24'h0, `LCDH_R_STATUS}, 32'h0);
      n++;
    end while (rd_v[1] !== 1'b0 && n < 50);
    if (n >= 50) begin
      check("busy wait", 32'h0, 32'h1);
      end_sim();
    end
  endtask : cmd
  task automatic wr_chk(input lcdh_reg_t r, input logic [7:0] v, input logic [7:0] e,
                        input logic bad);
    cmd(r, v, 1'b0);
    check("device reg", {24'h0, e}, {24'h0, u_dev.reg_q[r]});
    if (bad) begin
      check("error code", 32'h1, {30'h0, rd_v[3:2]});
    end
  endtask : wr_chk
  task automatic t_reset;
    ahb(1'b0, {24'h0, `LCDH_R_STATUS}, 32'h0);
    check("status shadows", 32'h0, {16'h0, rd_v[23:8]});
    ahb(1'b0, {24'h0, `LCDH_R_WDATA}, 32'h0);
    check("lvl clk mode0", {8'h0, `LCDH_LVL_RESET, 16'h0}, rd_v);
    ahb(1'b0, 32'h14, 32'h0);
    check("input gates", 32'h0, rd_v);
  endtask : t_reset
  task automatic t_subsystem_clock_option;
    wr_chk(LCDH_K_SUBSYSTEM_CLOCK_OPTION, 8'h90, 8'h90, 1'b0);
    check("select changed", 32'h1, {31'h0, rd_v[4]});
    wr_chk(LCDH_K_SUBSYSTEM_CLOCK_OPTION, 8'h80, 8'h90, 1'b1);
  endtask : t_subsystem_clock_option
  task automatic t_isc;
    wr_chk(LCDH_K_ISC, 8'h03, 8'h03, 1'b0);
    cmd(LCDH_K_ISC, 8'h00, 1'b1);
    ahb(1'b0, {24'h0, `LCDH_R_RDATA}, 32'h0);
    check("read data", 32'h3, rd_v);
  endtask : t_isc
  task automatic t_div;
    wr_chk(LCDH_K_MODE0, 8'h15, 8'h15, 1'b0);
    wr_chk(LCDH_K_MODE1, 8'h08, 8'h00, 1'b1);
    wr_chk(LCDH_K_MODE1, 8'h20, 8'h00, 1'b1);
    wr_chk(LCDH_K_MODE1, 8'h01, 8'h00, 1'b1);
    wr_chk(LCDH_K_CLK, 8'hC4, 8'h00, 1'b1);
    wr_chk(LCDH_K_CLK, 8'h2B, 8'h2B, 1'b0);
    wr_chk(LCDH_K_CLK, 8'h08, 8'h08, 1'b0);
  endtask : t_div
  task automatic t_boost;
    wr_chk(LCDH_K_MODE0, 8'h4D, 8'h4D, 1'b0);
    wr_chk(LCDH_K_CLK, 8'h05, 8'h08, 1'b1);
    wr_chk(LCDH_K_LVL, 8'h24, `LCDH_LVL_RESET, 1'b1);
    wr_chk(LCDH_K_LVL, 8'h13, 8'h13, 1'b0);
    check("settle running", 32'h1, {31'h0, rd_v[0]});
    wr_chk(LCDH_K_MODE1, 8'h10, 8'h00, 1'b1);
    wr_chk(LCDH_K_MODE1, 8'h21, 8'h00, 1'b1);
    wr_chk(LCDH_K_MODE1, 8'h01, 8'h01, 1'b0);
    wr_chk(LCDH_K_MODE1, 8'hC9, 8'hC9, 1'b0);
    check("mode1 shadow", 32'hC9, {24'h0, rd_v[15:8]});
    wr_chk(LCDH_K_MODE1, 8'hE9, 8'hC9, 1'b1);
    wr_chk(LCDH_K_CLK, 8'h07, 8'h08, 1'b1);
    wr_chk(LCDH_K_MODE1, 8'h09, 8'h09, 1'b0);
    wr_chk(LCDH_K_MODE0, 8'h0D, 8'h0D, 1'b0);
    wr_chk(LCDH_K_MODE1, 8'h00, 8'h00, 1'b0);
    check("idle mode1", 32'h0, {24'h0, rd_v[15:8]});
  endtask : t_boost
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_count = 0;
    check_count = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_subsystem_clock_option();
    t_isc();
    t_div();
    t_boost();
    end_sim();
  end
endmodule : lcdh_ctrl_tb_top
